/* adc_seq_pkg.sv */
// Constants, register map and state encoding for the conversion sequencer
`default_nettype none
package adc_seq_pkg;
    // Register byte addresses (one 32-bit word each, data in bits 7:0)
    localparam logic [7:0] OFS_CHAN_CTRL   = 8'h00;
    localparam logic [7:0] OFS_TRIG_CMP    = 8'h04;
    localparam logic [7:0] OFS_CLOCK_CFG   = 8'h08;
    localparam logic [7:0] OFS_CMP_HIGH    = 8'h0C;
    localparam logic [7:0] OFS_CMP_LOW     = 8'h10;
    localparam logic [7:0] OFS_RESULT_HIGH = 8'h14;
    localparam logic [7:0] OFS_RESULT_LOW  = 8'h18;

    // Field positions
    localparam int DONE_BIT     = 7;
    localparam int IRQ_EN_BIT   = 6;
    localparam int CONT_BIT     = 5;
    localparam int ACTIVE_BIT   = 7;
    localparam int HW_TRIG_BIT  = 6;
    localparam int CMP_EN_BIT   = 5;
    localparam int CMP_GT_BIT   = 4;
    localparam int LOW_PWR_BIT  = 7;
    localparam int DIV_LSB      = 5;
    localparam int LONG_BIT     = 4;
    localparam int MODE_LSB     = 2;
    localparam int SRC_LSB      = 0;

    // Field values and masks
    localparam logic [4:0] CHAN_OFF      = 5'h1F;
    localparam logic [1:0] MODE_10BIT    = 2'h2;
    localparam logic [1:0] SRC_ASYNC     = 2'h3;
    localparam logic [1:0] SRC_BUS_DIV2  = 2'h1;
    localparam logic [1:0] SRC_ALT       = 2'h2;
    localparam logic [7:0] CHAN_RST      = 8'h1F;
    localparam logic [7:0] TRIG_WR_MASK  = 8'h70;
    localparam logic [7:0] ZERO_RST      = 8'h00;

    // Timing
    localparam int CLK_PERIOD_NS  = 4;
    localparam int STARTUP_NS     = 5000;
    localparam int STARTUP_CYC    = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OVERHEAD_CYC   = 5;
    localparam int SAMPLE_SHORT   = 3;
    localparam int SAMPLE_LONG    = 23;
    localparam int FIRST_EXTRA    = 3;
    localparam int APPROX_8BIT    = 14;
    localparam int APPROX_10BIT   = 17;
    localparam int ASYNC_DIV      = 4;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_OVERHEAD = 3'b001,
        ST_STARTUP  = 3'b011,
        ST_SAMPLE   = 3'b010,
        ST_APPROX   = 3'b110,
        ST_XFER     = 3'b111
    } conv_state_t;
endpackage
`default_nettype wire

/* conv_clk_if.sv */
// Link between the sequencer and its converter clock divider
`default_nettype none
interface conv_clk_if;
    logic [1:0] src_sel;
    logic [1:0] div_sel;
    logic       run;
    logic       async_run;
    logic       tick;
    modport gen  (input src_sel, input div_sel, input run, input async_run, output tick);
    modport user (output src_sel, output div_sel, output run, output async_run, input tick);
endinterface
`default_nettype wire

/* conv_clock_gen.sv */
// Converter clock enable: source select, async generator and 1/2/4/8 divider
`default_nettype none
module conv_clock_gen (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic nrst,
    // Alternate clock pin
    input  wire logic alternate_clock,
    // Sequencer side
    conv_clk_if.gen   ck
);
    typedef struct packed {
        logic [2:0] div_cnt;
        logic       half;
        logic       alt_s1;
        logic       alt_s2;
        logic       alt_s3;
        logic [7:0] async_cnt;
        logic       tick;
    } gen_t;

    gen_t q_reg;
    gen_t q_next;
    logic src_tick;
    logic [2:0] div_top;

    always_comb begin
        q_next        = q_reg;
        q_next.alt_s1 = alternate_clock;
        q_next.alt_s2 = q_reg.alt_s1;
        q_next.alt_s3 = q_reg.alt_s2;
        q_next.half   = ~q_reg.half;
        q_next.tick   = 1'b0;
        // Async generator only runs while a conversion needs it
        if (ck.async_run) begin
            q_next.async_cnt = (q_reg.async_cnt == 8'(adc_seq_pkg::ASYNC_DIV - 1))
                               ? 8'h00 : q_reg.async_cnt + 8'h01;
        end else begin
            q_next.async_cnt = 8'h00;
        end
        case (ck.src_sel)
            adc_seq_pkg::SRC_BUS_DIV2: src_tick = q_reg.half;
            adc_seq_pkg::SRC_ALT:      src_tick = q_reg.alt_s2 & ~q_reg.alt_s3;
            adc_seq_pkg::SRC_ASYNC:    src_tick = ck.async_run &&
                                           q_reg.async_cnt == 8'(adc_seq_pkg::ASYNC_DIV - 1);
            default:                   src_tick = 1'b1;
        endcase
        div_top = 3'((1 << ck.div_sel) - 1); // [R26]
        if (!ck.run) begin
            q_next.div_cnt = 3'h0;
        end else if (src_tick) begin
            if (q_reg.div_cnt >= div_top) begin
                q_next.div_cnt = 3'h0;
                q_next.tick    = 1'b1;
            end else begin
                q_next.div_cnt = q_reg.div_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign ck.tick = q_reg.tick;
endmodule
`default_nettype wire

/* adc_conversion_sequencer.sv */
// Conversion sequencer with Wishbone register file, compare and result interlock
//
// How it works
// R1: Software mode: control write starts conversion unless channel off.
// R2: Hardware mode: trigger event starts a conversion.
// R3: Continuous mode restarts after each result transfer.
// R4: Transfer into result registers sets done flag.
// R5: 10-bit half-read result blocks transfer, discards result.
// R6: Single compare-false conversion ignores blocking, stops.
// R7: Other blocked transfers immediately start another conversion.
// R8: Software must not read results mid single conversion.
// R9: Control write aborts current, starts new unless off.
// R10: Writes to other control registers abort conversion.
// R11: Reset and stop without async clock abort.
// R12: Abort keeps results; reset clears them.
// R13: Idle until started; async clock enabled if selected.
// R14: Sample short/long, then approximate, then transfer.
// R15: First conversion: 20/23/40/43 converter cycles plus 5 bus.
// R16: Async source adds 5 us start-up to first.
// R17: Subsequent continuous: 17/20/37/40 converter cycles.
// R18: Compare adds two's complement; greater-select picks condition.
// R19: Compare-true stores the difference as the result.
// R20: Compare-false sets no flag, transfers nothing.
// R21: Wait mode: conversions finish, restart, completion wakes.
// R22: Bus, half bus and async clocks run in wait.
// R23: All-ones channel select disables the converter.
// R24: Compare active only while compare enable set.
// R25: Trigger rising edge starts; edges while busy ignored.
// R26: Converter clock is source divided by 1/2/4/8.
// R27: High result read arms interlock; low read releases.
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`default_nettype none
module adc_conversion_sequencer (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Pins and MCU state
    input  wire logic        hw_trigger_in,
    input  wire logic        alternate_clock,
    input  wire logic        stop_mode_in,
    input  wire logic        wait_mode_in,
    // Analog core
    input  wire logic [9:0]  sar_result_in,
    output logic      [4:0]  channel_select,
    output logic             sample_phase,
    output logic             approx_phase,
    output logic             low_power_cfg,
    output logic             async_clk_enable,
    // Completion
    output logic             done_irq,
    output logic             wake_req
);
    typedef struct packed {
        logic [6:0]                chan;
        logic [2:0]                trig;
        logic [7:0]                cfg;
        logic [1:0]                cvh;
        logic [7:0]                cvl;
        logic [1:0]                rh;
        logic [7:0]                rl;
        logic                      done;
        logic                      armed;
        adc_seq_pkg::conv_state_t  st;
        logic [5:0]                cnt;
        logic [10:0]               wcnt;
        logic                      first;
        logic                      trg_s1;
        logic                      trg_s2;
        logic                      trg_s3;
        logic                      ack;
        logic [7:0]                rdat;
        logic                      irq;
    } seq_t;

    seq_t q_reg;
    seq_t q_next;

    conv_clk_if ck ();

    conv_clock_gen u_clk (
        .sys_clk         (sys_clk),
        .nrst            (nrst),
        .alternate_clock (alternate_clock),
        .ck              (ck)
    );

    function automatic logic [5:0] sample_len(input logic long_s, input logic first);
        sample_len = 6'(long_s ? adc_seq_pkg::SAMPLE_LONG : adc_seq_pkg::SAMPLE_SHORT)
                   + 6'(first ? adc_seq_pkg::FIRST_EXTRA : 0);
    endfunction

    function automatic logic [5:0] approx_len(input logic is10);
        approx_len = 6'(is10 ? adc_seq_pkg::APPROX_10BIT : adc_seq_pkg::APPROX_8BIT);
    endfunction

    logic        req;
    logic        wr;
    logic        rd;
    logic        wr_chan;
    logic        wr_other;
    logic        rd_high;
    logic        rd_low;
    logic        is10;
    logic        long_s;
    logic        hw_sel;
    logic        cmp_en;
    logic        cont;
    logic [1:0]  src;
    logic        trg_rise;
    logic        stop_abort;
    logic [9:0]  res10;
    logic [9:0]  cmp10;
    logic [10:0] sum11;
    logic        cmp_true;
    logic        cmp_fail;
    logic        blocked;
    logic        set_done;

    always_comb begin
        req      = wb_cyc_i & wb_stb_i & ~q_reg.ack;
        wr       = req & wb_we_i & wb_sel_i[0];
        rd       = req & ~wb_we_i;
        wr_chan  = wr && wb_adr_i == adc_seq_pkg::OFS_CHAN_CTRL;
        wr_other = wr && (wb_adr_i == adc_seq_pkg::OFS_TRIG_CMP
                       || wb_adr_i == adc_seq_pkg::OFS_CLOCK_CFG
                       || wb_adr_i == adc_seq_pkg::OFS_CMP_HIGH
                       || wb_adr_i == adc_seq_pkg::OFS_CMP_LOW);
        rd_high  = rd && wb_adr_i == adc_seq_pkg::OFS_RESULT_HIGH;
        rd_low   = rd && wb_adr_i == adc_seq_pkg::OFS_RESULT_LOW;
        is10     = q_reg.cfg[adc_seq_pkg::MODE_LSB +: 2] == adc_seq_pkg::MODE_10BIT;
        long_s   = q_reg.cfg[adc_seq_pkg::LONG_BIT];
        src      = q_reg.cfg[adc_seq_pkg::SRC_LSB +: 2];
        hw_sel   = q_reg.trig[2];
        cmp_en   = q_reg.trig[1]; // [R24]
        cont     = q_reg.chan[adc_seq_pkg::CONT_BIT];
        // Only the second and third stages are looked at
        trg_rise = q_reg.trg_s2 & ~q_reg.trg_s3;
        // Async source keeps converting through stop
        stop_abort = stop_mode_in && src != adc_seq_pkg::SRC_ASYNC; // [R11]
        res10    = is10 ? sar_result_in : {2'h0, sar_result_in[9:2]};
        cmp10    = is10 ? {q_reg.cvh, q_reg.cvl} : {2'h0, q_reg.cvl};
        sum11    = {1'b0, res10} + {1'b0, ~cmp10} + 11'h001; // [R18]
        cmp_true = q_reg.trig[0] ? sum11[10] : ~sum11[10]; // [R18]
        cmp_fail = cmp_en & ~cmp_true;
        blocked  = is10 & q_reg.armed; // [R5]
        set_done = q_reg.st == adc_seq_pkg::ST_XFER && !cmp_fail && !blocked
                   && !wr_chan && !wr_other && !stop_abort;
    end

    always_comb begin
        q_next        = q_reg;
        q_next.ack    = req;
        q_next.trg_s1 = hw_trigger_in;
        q_next.trg_s2 = q_reg.trg_s1;
        q_next.trg_s3 = q_reg.trg_s2;
        q_next.irq    = 1'b0;

        // Register reads; unmapped addresses read zero
        if (req) begin
            case (wb_adr_i)
                adc_seq_pkg::OFS_CHAN_CTRL:   q_next.rdat = {q_reg.done, q_reg.chan};
                adc_seq_pkg::OFS_TRIG_CMP:    q_next.rdat = {q_reg.st != adc_seq_pkg::ST_IDLE,
                                                             q_reg.trig, 4'h0};
                adc_seq_pkg::OFS_CLOCK_CFG:   q_next.rdat = q_reg.cfg;
                adc_seq_pkg::OFS_CMP_HIGH:    q_next.rdat = {6'h00, q_reg.cvh};
                adc_seq_pkg::OFS_CMP_LOW:     q_next.rdat = q_reg.cvl;
                adc_seq_pkg::OFS_RESULT_HIGH: q_next.rdat = {6'h00, q_reg.rh};
                adc_seq_pkg::OFS_RESULT_LOW:  q_next.rdat = q_reg.rl;
                default:                      q_next.rdat = 8'h00;
            endcase
        end

        if (wr) begin
            case (wb_adr_i)
                adc_seq_pkg::OFS_CHAN_CTRL: q_next.chan = wb_dat_i[6:0];
                adc_seq_pkg::OFS_TRIG_CMP:  q_next.trig = wb_dat_i[6:4];
                adc_seq_pkg::OFS_CLOCK_CFG: q_next.cfg  = wb_dat_i[7:0];
                adc_seq_pkg::OFS_CMP_HIGH:  q_next.cvh  = wb_dat_i[1:0];
                adc_seq_pkg::OFS_CMP_LOW:   q_next.cvl  = wb_dat_i[7:0];
                default: ;
            endcase
        end

        // Interlock: armed by high byte, released by low byte
        if (rd_low) begin
            q_next.armed = 1'b0; // [R27]
        end else if (rd_high && is10) begin
            q_next.armed = 1'b1; // [R27]
        end

        // Conversion control; aborts keep the result registers as they are
        if (wr_chan) begin
            q_next.cnt   = 6'h00;
            q_next.wcnt  = 11'h000;
            q_next.first = 1'b1;
            if (wb_dat_i[4:0] != adc_seq_pkg::CHAN_OFF && !hw_sel) begin
                q_next.st = adc_seq_pkg::ST_OVERHEAD; // [R1] [R9]
            end else begin
                q_next.st = adc_seq_pkg::ST_IDLE; // [R9] [R23]
            end
        end else if (wr_other || stop_abort) begin
            q_next.st = adc_seq_pkg::ST_IDLE; // [R10] [R11] [R12]
        end else begin
            case (q_reg.st)
                adc_seq_pkg::ST_IDLE: begin
                    // Wait mode does not block trigger starts
                    if (hw_sel && trg_rise && q_reg.chan[4:0] != adc_seq_pkg::CHAN_OFF) begin
                        q_next.st    = adc_seq_pkg::ST_OVERHEAD; // [R2] [R25] [R21]
                        q_next.wcnt  = 11'h000;
                        q_next.first = 1'b1;
                    end
                end
                adc_seq_pkg::ST_OVERHEAD: begin
                    q_next.wcnt = q_reg.wcnt + 11'h001;
                    // Divider latency and the transfer cycle are two of the bus cycles
                    if (q_reg.wcnt == 11'(adc_seq_pkg::OVERHEAD_CYC - 3)) begin // [R15]
                        q_next.wcnt = 11'h000;
                        q_next.cnt  = 6'h00;
                        q_next.st   = (src == adc_seq_pkg::SRC_ASYNC) ?
                                      adc_seq_pkg::ST_STARTUP : adc_seq_pkg::ST_SAMPLE;
                    end
                end
                adc_seq_pkg::ST_STARTUP: begin
                    q_next.wcnt = q_reg.wcnt + 11'h001;
                    if (q_reg.wcnt == 11'(adc_seq_pkg::STARTUP_CYC - 1)) begin // [R16]
                        q_next.st = adc_seq_pkg::ST_SAMPLE;
                    end
                end
                adc_seq_pkg::ST_SAMPLE: begin
                    if (ck.tick) begin
                        q_next.cnt = q_reg.cnt + 6'h01;
                        if (q_reg.cnt == sample_len(long_s, q_reg.first) - 6'h01) begin
                            q_next.cnt = 6'h00;
                            q_next.st  = adc_seq_pkg::ST_APPROX; // [R14] [R15] [R17]
                        end
                    end
                end
                adc_seq_pkg::ST_APPROX: begin
                    if (ck.tick) begin
                        q_next.cnt = q_reg.cnt + 6'h01;
                        if (q_reg.cnt == approx_len(is10) - 6'h01) begin
                            q_next.st = adc_seq_pkg::ST_XFER; // [R14]
                        end
                    end
                end
                adc_seq_pkg::ST_XFER: begin
                    q_next.cnt   = 6'h00;
                    q_next.first = ~cont;
                    if (cmp_fail) begin
                        // Compare false: nothing stored, single stops
                        q_next.st = cont ? adc_seq_pkg::ST_SAMPLE
                                         : adc_seq_pkg::ST_IDLE; // [R6] [R20]
                    end else if (blocked) begin
                        q_next.st = adc_seq_pkg::ST_SAMPLE; // [R5] [R7]
                    end else begin
                        if (cmp_en) begin
                            q_next.rh = is10 ? sum11[9:8] : 2'h0; // [R19]
                            q_next.rl = sum11[7:0]; // [R19]
                        end else begin
                            q_next.rh = is10 ? res10[9:8] : 2'h0; // [R4]
                            q_next.rl = res10[7:0];
                        end
                        q_next.st = cont ? adc_seq_pkg::ST_SAMPLE
                                         : adc_seq_pkg::ST_IDLE; // [R3]
                    end
                end
                default: q_next.st = adc_seq_pkg::ST_IDLE;
            endcase
        end

        // Flag: set beats a result-low read clear in the same cycle; a control write blocks the set
        if (set_done) begin
            q_next.done = 1'b1; // [R4]
            q_next.irq  = q_reg.chan[adc_seq_pkg::IRQ_EN_BIT]; // [R4] [R21]
        end else if (wr_chan || rd_low) begin
            q_next.done = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            q_reg      <= '0; // [R11] [R12]
            q_reg.chan <= adc_seq_pkg::CHAN_RST[6:0]; // [R23]
            q_reg.st   <= adc_seq_pkg::ST_IDLE;
        end else begin
            q_reg <= q_next;
        end
    end

    always_comb begin
        ck.src_sel   = src;
        ck.div_sel   = q_reg.cfg[adc_seq_pkg::DIV_LSB +: 2];
        ck.run       = q_reg.st == adc_seq_pkg::ST_SAMPLE || q_reg.st == adc_seq_pkg::ST_APPROX;
        // Generator powered only while converting on it
        ck.async_run = q_reg.st != adc_seq_pkg::ST_IDLE
                       && src == adc_seq_pkg::SRC_ASYNC; // [R13] [R22]
    end

    assign wb_ack_o         = q_reg.ack;
    assign wb_dat_o         = {24'h000000, q_reg.rdat};
    assign channel_select   = q_reg.chan[4:0];
    assign sample_phase     = q_reg.st == adc_seq_pkg::ST_SAMPLE;
    assign approx_phase     = q_reg.st == adc_seq_pkg::ST_APPROX;
    assign low_power_cfg    = q_reg.cfg[adc_seq_pkg::LOW_PWR_BIT];
    assign async_clk_enable = ck.async_run;
    assign done_irq         = q_reg.irq;
    assign wake_req         = q_reg.irq & wait_mode_in; // [R21]

    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sw_start_a: assert property (wr_chan && !hw_sel && wb_dat_i[4:0] != 5'h1F // [R1]
        |=> q_reg.st == adc_seq_pkg::ST_OVERHEAD) else $error("software start missed");
    chan_off_a: assert property (wr_chan && wb_dat_i[4:0] == 5'h1F // [R23]
        |=> q_reg.st == adc_seq_pkg::ST_IDLE) else $error("disabled channel converts");
    cfg_abort_a: assert property (wr_other // [R10]
        |=> q_reg.st == adc_seq_pkg::ST_IDLE && $stable(q_reg.rl)) else $error("no abort");
    done_set_a: assert property (q_reg.st == adc_seq_pkg::ST_XFER && !cmp_fail && !blocked
        && !wr && !stop_abort |=> q_reg.done) else $error("done not set"); // [R4]
    block_drop_a: assert property (q_reg.st == adc_seq_pkg::ST_XFER && blocked && !cmp_fail
        && !wr && !stop_abort |=> $stable(q_reg.rl) && $stable(q_reg.rh)
        && q_reg.st == adc_seq_pkg::ST_SAMPLE) else $error("blocked result kept"); // [R5]
    cmp_skip_a: assert property (q_reg.st == adc_seq_pkg::ST_XFER && cmp_fail && !cont
        && !wr && !stop_abort |=> q_reg.st == adc_seq_pkg::ST_IDLE
        && $stable(q_reg.done)) else $error("compare false handled wrongly"); // [R6]
    stop_abort_a: assert property (stop_abort && !wr_chan // [R11]
        |=> q_reg.st == adc_seq_pkg::ST_IDLE) else $error("stop did not abort");
    trig_ignore_a: assert property (q_reg.st != adc_seq_pkg::ST_IDLE && trg_rise && !wr // [R25]
        |=> !$rose(q_reg.st == adc_seq_pkg::ST_OVERHEAD))
        else $error("busy trigger restarted");
    overhead_a: assert property ($rose(q_reg.st == adc_seq_pkg::ST_OVERHEAD) // [R15]
        ##0 (!wr && !stop_abort) [*3] |-> q_reg.st == adc_seq_pkg::ST_OVERHEAD
        ##1 q_reg.st != adc_seq_pkg::ST_OVERHEAD) else $error("overhead length wrong");
    async_en_a: assert property (q_reg.st == adc_seq_pkg::ST_IDLE // [R13]
        |-> !async_clk_enable) else $error("async clock on while idle");
endmodule
`default_nettype wire

/* adc_conversion_sequencer_test.sv */
// Self-checking bench for the conversion sequencer
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module adc_conversion_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk  = 1'b0;
    logic        nrst     = 1'b0;
    logic        req      = 1'b0;
    logic        we       = 1'b0;
    logic [7:0]  adr      = 8'h00;
    logic [31:0] wdat     = 32'h0;
    logic [3:0]  sel      = 4'hF;
    logic        trig     = 1'b0;
    logic        wmode    = 1'b0;
    logic        stop     = 1'b0;
    logic [9:0]  sar      = 10'h000;
    logic [31:0] rdat;
    logic        ack;
    logic        dirq;
    logic        wake;
    logic        sph;
    logic        aph;
    logic        lpc;
    logic        ace;
    logic [4:0]  chs;
    logic [1:0]  ph;
    logic        got;
    logic [7:0]  q;
    int          n;
    int          failures = 0;
    int          n_tests  = 0;

    adc_conversion_sequencer adc_conversion_sequencer_i (
        .sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(req), .wb_stb_i(req),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .hw_trigger_in(trig),
        .alternate_clock(1'b0), .stop_mode_in(stop), .wait_mode_in(wmode),
        .sar_result_in(sar), .channel_select(chs), .sample_phase(sph), .approx_phase(aph),
        .low_power_cfg(lpc), .async_clk_enable(ace), .done_irq(dirq), .wake_req(wake)
    );

    always #2 sys_clk = ~sys_clk;

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Ack is read just after the edge, so the pre-edge value is what counts
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge sys_clk);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge sys_clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        q = rdat[7:0];
        req <= 1'b0;
        if (ack !== 1'b1) begin
            failures++;
            final_report();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        `CHK(q, e)
    endtask

    // Not finding the pulse is a result here, judged by the caller
    task automatic wait_done(input int lim);
        got = 1'b0;
        ph  = 2'b00;
        n = 0;
        while (got !== 1'b1 && n < lim) begin
            @(posedge sys_clk);
            n++;
            got = dirq;
            ph  = ph | {sph, aph};
        end
    endtask

    task automatic t_reset();
        rd(8'h00, 8'h1F);
        rd(8'h14, 8'h00);
        rd(8'h18, 8'h00);
        rd(8'h1C, 8'h00);
        `CHK(chs, 5'h1F)
        $display("test reset done");
    endtask

    task automatic t_single();
        sar <= 10'h2A5;
        wmode <= 1'b1;
        wb(1'b1, 8'h08, 8'h80);
        wb(1'b1, 8'h00, 8'h41);
        wait_done(100);
        `CHK(got, 1'b1)
        `CHK((n <= 25), 1'b1)
        `CHK(ph, 2'b11)
        `CHK(lpc, 1'b1)
        `CHK(wake, 1'b1)
        rd(8'h00, 8'hC1);
        rd(8'h18, 8'hA9);
        wb(1'b1, 8'h00, 8'h5F);
        wait_done(60);
        `CHK(got, 1'b0)
        $display("test single done");
    endtask

    task automatic t_abort();
        sar <= 10'h0F0;
        wb(1'b1, 8'h00, 8'h41);
        wb(1'b1, 8'h10, 8'h00);
        wait_done(60);
        `CHK(got, 1'b0)
        rd(8'h18, 8'hA9);
        wb(1'b1, 8'h00, 8'h41);
        wait_done(10);
        wb(1'b1, 8'h00, 8'h41);
        wait_done(100);
        `CHK(got, 1'b1)
        `CHK((n >= 20), 1'b1)
        rd(8'h18, 8'h3C);
        $display("test abort done");
    endtask

    task automatic t_cmp();
        wb(1'b1, 8'h10, 8'h10);
        wb(1'b1, 8'h0C, 8'h00);
        wb(1'b1, 8'h04, 8'h30);
        wb(1'b1, 8'h00, 8'h41);
        wait_done(100);
        `CHK(got, 1'b1)
        rd(8'h18, 8'h2C);
        wb(1'b1, 8'h04, 8'h20);
        wb(1'b1, 8'h00, 8'h41);
        wait_done(100);
        `CHK(got, 1'b0)
        rd(8'h18, 8'h2C);
        rd(8'h04, 8'h20);
        $display("test compare done");
    endtask

    task automatic t_hw();
        wb(1'b1, 8'h04, 8'h40);
        wb(1'b1, 8'h00, 8'h41);
        wait_done(60);
        `CHK(got, 1'b0)
        trig <= 1'b1;
        wait_done(10);
        trig <= 1'b0;
        wait_done(4);
        trig <= 1'b1;
        wait_done(100);
        `CHK(got, 1'b1)
        wait_done(60);
        `CHK(got, 1'b0)
        trig <= 1'b0;
        $display("test trigger done");
    endtask

    task automatic t_cont();
        sar <= 10'h2A5;
        wb(1'b1, 8'h04, 8'h00);
        wb(1'b1, 8'h00, 8'h61);
        wait_done(100);
        wait_done(100);
        `CHK(got, 1'b1)
        `CHK((n <= 20), 1'b1)
        wb(1'b1, 8'h08, 8'h08);
        wb(1'b1, 8'h00, 8'h61);
        wait_done(100);
        rd(8'h14, 8'h02);
        wait_done(60);
        `CHK(got, 1'b0)
        rd(8'h18, 8'hA5);
        wait_done(60);
        `CHK(got, 1'b1)
        wb(1'b1, 8'h00, 8'h1F);
        $display("test continuous done");
    endtask

    // Async source survives stop; bus source is aborted by it
    task automatic t_async();
        stop <= 1'b1;
        wb(1'b1, 8'h08, 8'h03);
        wb(1'b1, 8'h00, 8'h41);
        `CHK(ace, 1'b1)
        wait_done(1400);
        `CHK(got, 1'b1)
        `CHK((n <= 1335), 1'b1)
        `CHK(ace, 1'b0)
        wb(1'b1, 8'h08, 8'h00);
        wb(1'b1, 8'h00, 8'h41);
        wait_done(60);
        `CHK(got, 1'b0)
        stop <= 1'b0;
        $display("test async clock done");
    endtask

    initial begin
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        t_reset();
        t_single();
        t_abort();
        t_cmp();
        t_hw();
        t_cont();
        t_async();
        final_report();
    end
endmodule
`default_nettype wire
